// [hw/devcfg_pkg.sv]
package devcfg_pkg;

    // ========================================================================
    // Register indices. Each index is one 32-bit word at byte address 4*index.
    // ========================================================================
    localparam int          IDX_W            = 12;
    localparam logic [11:0] IDX_CONFIG_LO    = 12'h880;
    localparam logic [11:0] IDX_CONFIG_HI    = 12'h881;
    localparam logic [11:0] IDX_PART_NUMBER  = 12'h882;
    localparam logic [11:0] IDX_SILICON_REV  = 12'h883;
    localparam logic [11:0] IDX_REGION_BASE  = 12'h884;
    localparam logic [11:0] IDX_REGION_SPAN  = 12'h885;
    localparam logic [11:0] IDX_RESERVED_END = 12'h9ff;

    // ========================================================================
    // Configuration word field positions.
    // ========================================================================
    localparam int BIT_PROTECT_EN   = 19;
    localparam int BIT_PROTECT_EN_H = 3;
    localparam int BIT_RESET_PIN    = 5;
    localparam int BIT_VECTOR_MAP   = 3;

    // ========================================================================
    // Values after reset and fixed reserved field values.
    // ========================================================================
    localparam logic        RST_PROTECT_EN  = 1'b1;
    localparam logic [2:0]  FIXED_CFG_18_16 = 3'b111;
    localparam logic [2:0]  FIXED_CFG_2_0   = 3'b011;
    localparam logic [15:0] RST_REGION_BASE = 16'h0100;
    localparam logic [15:0] RST_REGION_SPAN = 16'h00ff;

    // ========================================================================
    // AXI4-Lite response codes.
    // ========================================================================
    localparam logic [1:0]  RESP_OKAY       = 2'b00;
    localparam logic [1:0]  RESP_SLVERR     = 2'b10;

endpackage : devcfg_pkg

// [hw/reg_word.sv]
`timescale 1ns/1ps

// One writable register with two byte lanes and a constant reset value.
module reg_word #(
    parameter int          WIDTH = 16,
    parameter logic [15:0] RESET = 16'h0000
) (
    input  wire logic             clk,
    input  wire logic             sys_rst,
    input  wire logic             wrEn,
    input  wire logic [1:0]       byteEn,
    input  wire logic [WIDTH-1:0] wrData,
    output logic      [WIDTH-1:0] value
);

    // Each enabled lane loads its byte; disabled lanes keep their contents.
    always_ff @(posedge clk or posedge sys_rst) begin
        if (sys_rst) begin
            value <= RESET[WIDTH-1:0];
        end else if (wrEn) begin
            if (byteEn[0]) begin
                value[7:0] <= wrData[7:0];
            end
            if (byteEn[1]) begin
                value[WIDTH-1:8] <= wrData[WIDTH-1:8];
            end
        end
    end

endmodule : reg_word

// [hw/device_config_protect_regs.sv]
// Implementation choice: the AXI4-Lite interface to the registers.
`timescale 1ns/1ps

module device_config_protect_regs #(
    parameter int          ADDR_W        = 14,
    parameter logic [15:0] PART_NUMBER   = 16'h00a5, // Arbitrary value.
    parameter logic [15:0] SILICON_REV   = 16'h0000  // Arbitrary value.
) (
    input  wire logic              clk,
    input  wire logic              sys_rst,
    input  wire logic [ADDR_W-1:0] s_axi_awaddr,
    input  wire logic              s_axi_awvalid,
    output logic                   s_axi_awready,
    input  wire logic [31:0]       s_axi_wdata,
    input  wire logic [3:0]        s_axi_wstrb,
    input  wire logic              s_axi_wvalid,
    output logic                   s_axi_wready,
    output logic [1:0]             s_axi_bresp,
    output logic                   s_axi_bvalid,
    input  wire logic              s_axi_bready,
    input  wire logic [ADDR_W-1:0] s_axi_araddr,
    input  wire logic              s_axi_arvalid,
    output logic                   s_axi_arready,
    output logic [31:0]            s_axi_rdata,
    output logic [1:0]             s_axi_rresp,
    output logic                   s_axi_rvalid,
    input  wire logic              s_axi_rready,
    input  wire logic              resetPinLevel,
    input  wire logic              vectorMapSelect,
    input  wire logic              protectedWriteAllow,
    output logic                   wrRdProtectEn,
    output logic [15:0]            protectRegionBase,
    output logic [15:0]            protectRegionSpan
);

    import devcfg_pkg::*;

    // ========================================================================
    // Write channel holding.
    // ========================================================================
    logic              awHeld_q;
    logic              wHeld_q;
    logic [IDX_W-1:0]  awIdx_q;
    logic [31:0]       wData_q;
    logic [3:0]        wStrb_q;
    logic              awTake;
    logic              wTake;
    logic              doWrite;
    logic              wrAllowed;
    logic              awHeld_d;
    logic              wHeld_d;

    assign awTake    = s_axi_awvalid & s_axi_awready;
    assign wTake     = s_axi_wvalid & s_axi_wready;
    // A write completes only when no earlier response is still waiting.
    assign doWrite   = awHeld_q & wHeld_q & ~s_axi_bvalid;
    assign wrAllowed = doWrite & protectedWriteAllow;
    assign awHeld_d  = (awHeld_q | awTake) & ~doWrite;
    assign wHeld_d   = (wHeld_q | wTake) & ~doWrite;

    // Address and data are taken in either order and kept until both exist.
    always_ff @(posedge clk or posedge sys_rst) begin
        if (sys_rst) begin
            awHeld_q      <= 1'b0;
            wHeld_q       <= 1'b0;
            s_axi_awready <= 1'b1;
            s_axi_wready  <= 1'b1;
            awIdx_q       <= '0;
            wData_q       <= '0;
            wStrb_q       <= '0;
        end else begin
            awHeld_q      <= awHeld_d;
            wHeld_q       <= wHeld_d;
            s_axi_awready <= ~awHeld_d;
            s_axi_wready  <= ~wHeld_d;
            if (awTake) begin
                awIdx_q <= IDX_W'(s_axi_awaddr[ADDR_W-1:2]);
            end
            if (wTake) begin
                wData_q <= s_axi_wdata;
                wStrb_q <= s_axi_wstrb;
            end
        end
    end

    // ========================================================================
    // Address classification.
    // ========================================================================
    function automatic logic idxMapped(input logic [IDX_W-1:0] idx);
        idxMapped = (idx >= IDX_CONFIG_LO) && (idx <= IDX_RESERVED_END);
    endfunction : idxMapped

    // Write response: unmapped words answer with an error, others okay.
    always_ff @(posedge clk or posedge sys_rst) begin
        if (sys_rst) begin
            s_axi_bvalid <= 1'b0;
            s_axi_bresp  <= RESP_OKAY;
        end else if (doWrite) begin
            s_axi_bvalid <= 1'b1;
            s_axi_bresp  <= idxMapped(awIdx_q) ? RESP_OKAY : RESP_SLVERR;
        end else if (s_axi_bready) begin
            s_axi_bvalid <= 1'b0;
        end
    end

    // ========================================================================
    // Protection enable and region registers.
    // ========================================================================
    logic protectEn_q;
    logic baseWr;
    logic spanWr;

    // The enable is reachable through the low word at bit 19 and through the
    // high half-word alias at bit 3; a blocked write leaves it untouched.
    always_ff @(posedge clk or posedge sys_rst) begin
        if (sys_rst) begin
            protectEn_q <= RST_PROTECT_EN;
        end else if (wrAllowed) begin
            if (awIdx_q == IDX_CONFIG_LO && wStrb_q[2]) begin
                protectEn_q <= wData_q[BIT_PROTECT_EN];
            end else if (awIdx_q == IDX_CONFIG_HI && wStrb_q[0]) begin
                protectEn_q <= wData_q[BIT_PROTECT_EN_H];
            end
        end
    end

    // The enable leaves as a flop, driven straight from protectEn_q.
    assign wrRdProtectEn = protectEn_q;

    assign baseWr = wrAllowed && (awIdx_q == IDX_REGION_BASE);
    assign spanWr = wrAllowed && (awIdx_q == IDX_REGION_SPAN);

    reg_word #(
        .WIDTH (16),
        .RESET (RST_REGION_BASE)
    ) baseReg (
        .clk     (clk),
        .sys_rst (sys_rst),
        .wrEn    (baseWr),
        .byteEn  (wStrb_q[1:0]),
        .wrData  (wData_q[15:0]),
        .value   (protectRegionBase)
    );

    reg_word #(
        .WIDTH (16),
        .RESET (RST_REGION_SPAN)
    ) spanReg (
        .clk     (clk),
        .sys_rst (sys_rst),
        .wrEn    (spanWr),
        .byteEn  (wStrb_q[1:0]),
        .wrData  (wData_q[15:0]),
        .value   (protectRegionSpan)
    );

    // ========================================================================
    // Vector-map strap capture.
    // ========================================================================
    logic vectorMapStatus_q;
    logic strapTaken_q;

    // The strap cannot be loaded under the asynchronous reset, so it is caught
    // on the first edge after release and then held.
    always_ff @(posedge clk or posedge sys_rst) begin
        if (sys_rst) begin
            strapTaken_q      <= 1'b0;
            vectorMapStatus_q <= 1'b0;
        end else if (!strapTaken_q) begin
            strapTaken_q      <= 1'b1;
            vectorMapStatus_q <= vectorMapSelect;
        end
    end

    // ========================================================================
    // Read path.
    // ========================================================================
    logic [31:0]      configWord;
    logic [31:0]      rdWord;
    logic [IDX_W-1:0] arIdx;
    logic             arTake;

    // Reserved fields return their fixed values; the pin bit is not stored.
    always_comb begin
        configWord                 = 32'h0000_0000;
        configWord[BIT_PROTECT_EN] = protectEn_q;
        configWord[18:16]          = FIXED_CFG_18_16;
        configWord[BIT_RESET_PIN]  = resetPinLevel;
        configWord[BIT_VECTOR_MAP] = vectorMapStatus_q;
        configWord[2:0]            = FIXED_CFG_2_0;
    end

    assign arIdx  = IDX_W'(s_axi_araddr[ADDR_W-1:2]);
    assign arTake = s_axi_arvalid & s_axi_arready;

    // Decode of the word map; reserved indices read zero.
    always_comb begin
        case (arIdx)
            IDX_CONFIG_LO:   rdWord = configWord;
            IDX_CONFIG_HI:   rdWord = {16'h0000, configWord[31:16]};
            IDX_PART_NUMBER: rdWord = {16'h0000, PART_NUMBER};
            IDX_SILICON_REV: rdWord = {16'h0000, SILICON_REV};
            IDX_REGION_BASE: rdWord = {16'h0000, protectRegionBase};
            IDX_REGION_SPAN: rdWord = {16'h0000, protectRegionSpan};
            default:         rdWord = 32'h0000_0000;
        endcase
    end

    // One read at a time; the address channel closes until data is taken.
    always_ff @(posedge clk or posedge sys_rst) begin
        if (sys_rst) begin
            s_axi_arready <= 1'b1;
            s_axi_rvalid  <= 1'b0;
            s_axi_rdata   <= 32'h0000_0000;
            s_axi_rresp   <= RESP_OKAY;
        end else if (arTake) begin
            s_axi_arready <= 1'b0;
            s_axi_rvalid  <= 1'b1;
            s_axi_rdata   <= rdWord;
            s_axi_rresp   <= idxMapped(arIdx) ? RESP_OKAY : RESP_SLVERR;
        end else if (s_axi_rvalid && s_axi_rready) begin
            s_axi_arready <= 1'b1;
            s_axi_rvalid  <= 1'b0;
        end
    end

    // ========================================================================
    // Assertions.
    // ========================================================================
    default clocking cb @(posedge clk); endclocking
    default disable iff (sys_rst);

    property p_enable_write;
        wrAllowed && awIdx_q == IDX_CONFIG_LO && wStrb_q[2]
            |=> wrRdProtectEn == $past(wData_q[BIT_PROTECT_EN]);
    endproperty
    a_enable_write: assert property (p_enable_write)
        else $error("Protection enable did not take the written bit.");

    property p_blocked_write;
        doWrite && !protectedWriteAllow
            |=> $stable(wrRdProtectEn) && $stable(protectRegionBase)
                && $stable(protectRegionSpan);
    endproperty
    a_blocked_write: assert property (p_blocked_write)
        else $error("A write without allow changed a register.");

    property p_pin_live;
        arTake && arIdx == IDX_CONFIG_LO
            |=> s_axi_rdata[BIT_RESET_PIN] == $past(resetPinLevel);
    endproperty
    a_pin_live: assert property (p_pin_live)
        else $error("Reset pin bit does not match the pin.");

    property p_strap;
        arTake && arIdx == IDX_CONFIG_LO
            |=> s_axi_rdata[BIT_VECTOR_MAP] == $past(vectorMapStatus_q)
                && s_axi_rdata[BIT_PROTECT_EN] == $past(wrRdProtectEn);
    endproperty
    a_strap: assert property (p_strap)
        else $error("Strap or enable bit read back wrong.");

    property p_fixed_bits;
        arTake && arIdx == IDX_CONFIG_LO
            |=> s_axi_rdata[31:20] == 12'h000
                && s_axi_rdata[18:16] == FIXED_CFG_18_16
                && s_axi_rdata[15:6] == 10'h000
                && s_axi_rdata[2:0] == FIXED_CFG_2_0;
    endproperty
    a_fixed_bits: assert property (p_fixed_bits)
        else $error("Reserved configuration bits read wrong.");

    property p_base_read;
        arTake && arIdx == IDX_REGION_BASE
            |=> s_axi_rdata == {16'h0000, $past(protectRegionBase)};
    endproperty
    a_base_read: assert property (p_base_read)
        else $error("Region base read back wrong.");

    property p_span_write;
        spanWr && wStrb_q[1:0] == 2'b11
            |=> protectRegionSpan == $past(wData_q[15:0]);
    endproperty
    a_span_write: assert property (p_span_write)
        else $error("Region span did not take the written word.");

    property p_unmapped;
        arTake && !idxMapped(arIdx)
            |=> s_axi_rresp == RESP_SLVERR && s_axi_rdata == 32'h0;
    endproperty
    a_unmapped: assert property (p_unmapped)
        else $error("Unmapped read did not answer with an error.");

    property p_bresp_hold;
        s_axi_bvalid && !s_axi_bready |=> s_axi_bvalid;
    endproperty
    a_bresp_hold: assert property (p_bresp_hold)
        else $error("Write response dropped before acceptance.");

    c_cfg_write: cover property (wrAllowed && awIdx_q == IDX_CONFIG_LO);
    c_blocked:   cover property (doWrite && !protectedWriteAllow);
    c_span_rd:   cover property (arTake && arIdx == IDX_REGION_SPAN);
    c_unmapped:  cover property (arTake && !idxMapped(arIdx));

endmodule : device_config_protect_regs

// [testbench/device_config_protect_regs_bench.sv]
`timescale 1ns/1ps

`define CHK(nm, e, g) begin \
    comparisons++; \
    if ((g) !== (e)) begin \
        $display("unexpected %s expected %h seen %h", nm, e, g); \
        n_mismatch++; \
    end \
end

module device_config_protect_regs_bench;
    import devcfg_pkg::*;

    // ========================================================================
    // Constants and bench signals.
    // ========================================================================
    localparam logic [15:0] PART  = 16'h0c3a; // Arbitrary value.
    localparam logic [15:0] REV   = 16'h0007; // Arbitrary value.
    localparam logic [13:0] A_CFG = {IDX_CONFIG_LO, 2'b00};
    localparam logic [13:0] A_HI  = {IDX_CONFIG_HI, 2'b00};
    localparam logic [13:0] A_PN  = {IDX_PART_NUMBER, 2'b00};
    localparam logic [13:0] A_REV = {IDX_SILICON_REV, 2'b00};
    localparam logic [13:0] A_BAS = {IDX_REGION_BASE, 2'b00};
    localparam logic [13:0] A_SPN = {IDX_REGION_SPAN, 2'b00};
    localparam logic [13:0] A_RES = 14'h2218;
    localparam logic [13:0] A_END = {IDX_RESERVED_END, 2'b00};
    localparam logic [13:0] A_OUT = 14'h2800;

    logic        clk                 = 1'b0;
    logic        sys_rst             = 1'b1;
    logic [13:0] s_axi_awaddr        = 14'h0000;
    logic        s_axi_awvalid       = 1'b0;
    logic [31:0] s_axi_wdata         = 32'h0000_0000;
    logic [3:0]  s_axi_wstrb         = 4'h0;
    logic        s_axi_wvalid        = 1'b0;
    logic        s_axi_bready        = 1'b0;
    logic [13:0] s_axi_araddr        = 14'h0000;
    logic        s_axi_arvalid       = 1'b0;
    logic        s_axi_rready        = 1'b0;
    logic        resetPinLevel       = 1'b1;
    logic        vectorMapSelect     = 1'b1;
    logic        protectedWriteAllow = 1'b0;
    logic        s_axi_awready, s_axi_wready, s_axi_bvalid;
    logic        s_axi_arready, s_axi_rvalid, wrRdProtectEn;
    logic [1:0]  s_axi_bresp, s_axi_rresp;
    logic [31:0] s_axi_rdata;
    logic [15:0] protectRegionBase, protectRegionSpan;
    int          n_mismatch  = 0;
    int          comparisons = 0;

    // A 250 MHz clock.
    always #2 clk = ~clk;

    device_config_protect_regs #(
        .ADDR_W(14), .PART_NUMBER(PART), .SILICON_REV(REV)
    ) uut (
        .clk(clk), .sys_rst(sys_rst),
        .s_axi_awaddr(s_axi_awaddr), .s_axi_awvalid(s_axi_awvalid),
        .s_axi_awready(s_axi_awready), .s_axi_wdata(s_axi_wdata),
        .s_axi_wstrb(s_axi_wstrb), .s_axi_wvalid(s_axi_wvalid),
        .s_axi_wready(s_axi_wready), .s_axi_bresp(s_axi_bresp),
        .s_axi_bvalid(s_axi_bvalid), .s_axi_bready(s_axi_bready),
        .s_axi_araddr(s_axi_araddr), .s_axi_arvalid(s_axi_arvalid),
        .s_axi_arready(s_axi_arready), .s_axi_rdata(s_axi_rdata),
        .s_axi_rresp(s_axi_rresp), .s_axi_rvalid(s_axi_rvalid),
        .s_axi_rready(s_axi_rready), .resetPinLevel(resetPinLevel),
        .vectorMapSelect(vectorMapSelect),
        .protectedWriteAllow(protectedWriteAllow),
        .wrRdProtectEn(wrRdProtectEn),
        .protectRegionBase(protectRegionBase),
        .protectRegionSpan(protectRegionSpan)
    );

    // ========================================================================
    // Expected words and bus tasks.
    // ========================================================================
    // Full configuration word as software should see it.
    function automatic logic [31:0] cfgWord(input logic en, input logic pin,
                                            input logic strap);
        return {12'h000, en, 3'b111, 10'h000, pin, 1'b0, strap, 3'b011};
    endfunction : cfgWord

    // A hung bus counts as a mismatch and ends the run at once.
    task automatic bus_timeout(input int n);
        if (n > 100) begin
            $display("unexpected bus timeout expected answer seen none");
            n_mismatch++;
            wrap_up();
        end
    endtask : bus_timeout

    // Address and data are offered together; each drops once it is taken.
    task automatic axi_write(input logic [13:0] a, input logic [31:0] d,
                             input logic [3:0] s, output logic [1:0] r);
        int   n;
        logic awDone, wDone, got;
        n = 0; awDone = 1'b0; wDone = 1'b0; got = 1'b0;
        // One edge passes so bready is never released and raised at once.
        @(posedge clk);
        s_axi_awaddr <= a; s_axi_awvalid <= 1'b1; s_axi_wdata <= d;
        s_axi_wstrb <= s; s_axi_wvalid <= 1'b1; s_axi_bready <= 1'b1;
        while (!got) begin
            @(posedge clk);
            n++;
            if (!awDone && s_axi_awready === 1'b1) begin
                awDone = 1'b1; s_axi_awvalid <= 1'b0;
            end
            if (!wDone && s_axi_wready === 1'b1) begin
                wDone = 1'b1; s_axi_wvalid <= 1'b0;
            end
            if (s_axi_bvalid === 1'b1) begin
                r = s_axi_bresp; got = 1'b1; s_axi_bready <= 1'b0;
            end
            bus_timeout(n);
        end
    endtask : axi_write

    task automatic axi_read(input logic [13:0] a, output logic [31:0] d,
                            output logic [1:0] r);
        int   n;
        logic got;
        n = 0; got = 1'b0;
        // One edge passes so rready is never released and raised at once.
        @(posedge clk);
        s_axi_araddr <= a; s_axi_arvalid <= 1'b1; s_axi_rready <= 1'b1;
        while (!got) begin
            @(posedge clk);
            n++;
            if (s_axi_arready === 1'b1) s_axi_arvalid <= 1'b0;
            if (s_axi_rvalid === 1'b1) begin
                d = s_axi_rdata; r = s_axi_rresp; got = 1'b1;
                s_axi_rready <= 1'b0;
            end
            bus_timeout(n);
        end
    endtask : axi_read

    task automatic chk_write(input logic [13:0] a, input logic [31:0] d,
                             input logic [3:0] s, input logic [1:0] er);
        logic [1:0] r;
        axi_write(a, d, s, r);
        `CHK("write response", er, r)
    endtask : chk_write

    task automatic chk_read(input logic [13:0] a, input logic [31:0] e,
                            input logic [1:0] er);
        logic [31:0] d;
        logic [1:0]  r;
        axi_read(a, d, r);
        `CHK("read data", e, d)
        `CHK("read response", er, r)
    endtask : chk_read

    // Reset is held twelve cycles; the strap is set up before release.
    task automatic do_reset(input logic strap);
        vectorMapSelect <= strap;
        sys_rst <= 1'b1;
        repeat (12) @(posedge clk);
        sys_rst <= 1'b0;
        repeat (3) @(posedge clk);
    endtask : do_reset

    task automatic wrap_up();
        $display("counts: comparisons %0d mismatches %0d",
                 comparisons, n_mismatch);
        if (n_mismatch == 0 && comparisons > 0) $display("TB: PASS");
        else $display("TB: FAIL");
        $finish;
    endtask : wrap_up

    // ========================================================================
    // Test sequence.
    // ========================================================================
    initial begin
        do_reset(1'b1);
        chk_read(A_CFG, cfgWord(1'b1, 1'b1, 1'b1), RESP_OKAY);
        chk_read(A_HI, 32'h0000_000f, RESP_OKAY);
        chk_read(A_PN, {16'h0000, PART}, RESP_OKAY);
        chk_read(A_REV, {16'h0000, REV}, RESP_OKAY);
        chk_read(A_BAS, 32'h0000_0100, RESP_OKAY);
        chk_read(A_SPN, 32'h0000_00ff, RESP_OKAY);
        `CHK("enable", 1'b1, wrRdProtectEn)
        $display("test reset_values done");
        // The pin is live while the strap stays as captured.
        vectorMapSelect <= 1'b0;
        resetPinLevel <= 1'b0;
        chk_read(A_CFG, cfgWord(1'b1, 1'b0, 1'b1), RESP_OKAY);
        resetPinLevel <= 1'b1;
        chk_read(A_CFG, cfgWord(1'b1, 1'b1, 1'b1), RESP_OKAY);
        $display("test status_bits done");
        // Without the allow state every write is dropped.
        chk_write(A_BAS, 32'h0000_1234, 4'hf, RESP_OKAY);
        chk_write(A_CFG, 32'h0000_0000, 4'h4, RESP_OKAY);
        chk_read(A_BAS, 32'h0000_0100, RESP_OKAY);
        `CHK("enable", 1'b1, wrRdProtectEn)
        $display("test blocked_writes done");
        // Allowed writes honour byte lanes and leave fixed bits alone.
        protectedWriteAllow <= 1'b1;
        chk_write(A_BAS, 32'hffff_1234, 4'h1, RESP_OKAY);
        chk_read(A_BAS, 32'h0000_0134, RESP_OKAY);
        `CHK("base", 16'h0134, protectRegionBase)
        chk_write(A_SPN, 32'h0000_0a5c, 4'h3, RESP_OKAY);
        `CHK("span", 16'h0a5c, protectRegionSpan)
        chk_write(A_CFG, 32'h0000_0000, 4'h4, RESP_OKAY);
        `CHK("enable", 1'b0, wrRdProtectEn)
        chk_write(A_CFG, 32'hffff_ffff, 4'hb, RESP_OKAY);
        chk_read(A_CFG, cfgWord(1'b0, 1'b1, 1'b1), RESP_OKAY);
        chk_write(A_HI, 32'h0000_0008, 4'h1, RESP_OKAY);
        `CHK("enable", 1'b1, wrRdProtectEn)
        chk_write(A_PN, 32'hffff_ffff, 4'hf, RESP_OKAY);
        chk_read(A_PN, {16'h0000, PART}, RESP_OKAY);
        $display("test allowed_writes done");
        // Reserved words read zero; beyond them the bus answers an error.
        chk_write(A_RES, 32'hffff_ffff, 4'hf, RESP_OKAY);
        chk_read(A_RES, 32'h0000_0000, RESP_OKAY);
        chk_read(A_END, 32'h0000_0000, RESP_OKAY);
        chk_read(A_OUT, 32'h0000_0000, RESP_SLVERR);
        chk_write(A_OUT, 32'hffff_ffff, 4'hf, RESP_SLVERR);
        $display("test reserved_space done");
        // A second reset restores values and captures the new strap.
        do_reset(1'b0);
        vectorMapSelect <= 1'b1;
        chk_read(A_CFG, cfgWord(1'b1, 1'b1, 1'b0), RESP_OKAY);
        chk_read(A_SPN, 32'h0000_00ff, RESP_OKAY);
        `CHK("base", 16'h0100, protectRegionBase)
        $display("test second_reset done");
        wrap_up();
    end

endmodule : device_config_protect_regs_bench
